/* shared/ffmo_pkg.sv */
// package: shared constants for the flip-flop and one-shot cell library
package ffmo_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned FFMO_CLK_PERIOD_PS = 5000;
  // tick of the pulse timer in ps: 1 us
  localparam int unsigned FFMO_TICK_PS = 1000000;
  localparam int unsigned FFMO_TICK_CYC =
    (FFMO_TICK_PS + FFMO_CLK_PERIOD_PS - 1) / FFMO_CLK_PERIOD_PS;
  // pulse length in ticks (1 us each): 0.001 ms .. 10000 ms, default 10 ms
  localparam int unsigned FFMO_DLY_MIN_TICKS = 1;
  localparam int unsigned FFMO_DLY_MAX_TICKS = 10000000;
  localparam int unsigned FFMO_DLY_DEF_TICKS = 10000;
  localparam int unsigned FFMO_DLY_W = 24;
  localparam int unsigned FFMO_TICK_W = 8;
  // ****************************************
  // reset levels
  // ****************************************
  localparam logic FFMO_LVL_LO = 1'h0;
  localparam logic FFMO_LVL_HI = 1'h1;
endpackage

/* rtl/ffmo_oneshot.sv */
// one-shot pulse generator with selectable edge and retrigger option
`timescale 1ns/10ps
module ffmo_oneshot
  import ffmo_pkg::*;
#(
  parameter bit FALL_EDGE = 1'b0,
  parameter int unsigned TICK_CYC = FFMO_TICK_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic trig_in,
  input wire logic retrig_en,
  input wire logic [FFMO_DLY_W-1:0] dly_ticks,
  output logic true_out,
  output logic inverse_out
);
  // the tick counter is FFMO_TICK_W bits wide, so longer ticks cannot count
  if (TICK_CYC < 1 || TICK_CYC >= (1 << FFMO_TICK_W)) begin : g_tick_chk
    $error("tick count out of range");
  end

  logic trig_d_ff;
  logic act_ff;
  logic [FFMO_TICK_W-1:0] tick_ff;
  logic [FFMO_DLY_W-1:0] cnt_ff;
  logic [FFMO_DLY_W-1:0] dly_eff;
  logic edge_hit;
  logic fire;
  logic tick_wrap;
  logic done;

  // ****************************************
  // edge detect and pulse timer
  // ****************************************
  // sampled against ref_clk, one cycle of latency on the edge
  assign edge_hit = FALL_EDGE ? (trig_d_ff & ~trig_in)
                              : (~trig_d_ff & trig_in);
  // zero length is clamped to the minimum of one tick
  assign dly_eff = (dly_ticks == '0) ? FFMO_DLY_W'(FFMO_DLY_MIN_TICKS) :
                   (dly_ticks > FFMO_DLY_W'(FFMO_DLY_MAX_TICKS)) ?
                   FFMO_DLY_W'(FFMO_DLY_MAX_TICKS) : dly_ticks;
  assign fire = edge_hit & (~act_ff | retrig_en);
  assign tick_wrap = (tick_ff == FFMO_TICK_W'(TICK_CYC - 1));
  // at or past the end, so shortening the length mid-pulse cannot hang it
  assign done = act_ff & tick_wrap &
                (cnt_ff >= dly_eff - FFMO_DLY_W'(1));

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      trig_d_ff <= FFMO_LVL_LO;
      act_ff <= FFMO_LVL_LO;
      tick_ff <= '0;
      cnt_ff <= '0;
    end else begin
      trig_d_ff <= trig_in;
      if (fire) begin
        act_ff <= FFMO_LVL_HI;
        tick_ff <= '0;
        cnt_ff <= '0;
      end else if (done) begin
        act_ff <= FFMO_LVL_LO;
      end else if (act_ff) begin
        tick_ff <= tick_wrap ? '0 : tick_ff + FFMO_TICK_W'(1);
        if (tick_wrap) begin
          cnt_ff <= cnt_ff + FFMO_DLY_W'(1);
        end
      end
    end
  end

  assign true_out = act_ff;
  assign inverse_out = ~act_ff;

  a_shot_starts: assert property (
    @(posedge ref_clk) disable iff (rst)
    edge_hit && !act_ff |=> true_out)
    else $error("one-shot did not start on edge");
  a_shot_ends: assert property (
    @(posedge ref_clk) disable iff (rst)
    done && !fire |=> !true_out)
    else $error("one-shot did not end after its length");
  a_shot_hold: assert property (
    @(posedge ref_clk) disable iff (rst)
    act_ff && !retrig_en && edge_hit && !done |=>
      true_out && (tick_ff != '0 || cnt_ff != '0))
    else $error("non-retriggerable shot restarted");
  a_shot_retrig: assert property (
    @(posedge ref_clk) disable iff (rst)
    act_ff && retrig_en && edge_hit |=>
      true_out && tick_ff == '0 && cnt_ff == '0)
    else $error("retriggerable shot did not restart");
  a_shot_inv: assert property (
    @(posedge ref_clk)
    inverse_out == !true_out)
    else $error("one-shot outputs not complementary");
endmodule

/* rtl/ffmo_cells.sv */
// cell library top: toggle cells, two one-shots and a data flip-flop
// Contract
// - reset-toggle cell shows true 0 and inverse 1 while its reset is low.
// - each toggle cell swaps both outputs on a rising toggle edge.
// - set-toggle cell shows true 1 and inverse 0 while its set is low.
// - each toggle cell holds its outputs when no rising edge occurs.
// - the rising one-shot pulses high for its length on a 0 to 1 trigger.
// - the falling one-shot pulses high for its length on a 1 to 0 trigger.
// - each one-shot drops its output by itself when the length expires.
// - a retriggerable one-shot restarts on a new edge, else ignores it.
// - pulse length spans 0.001 ms to 10000 ms and defaults to 10 ms; the cells take it only from the dly_ticks ports.
// - each one-shot drives its inverse output as not of its true output.
// - data cell set alone forces state 1, true 1 and inverse 0.
// - data cell reset alone forces state 0, true 0 and inverse 1.
// - data cell set and reset are active low; both low gives both out 1.
// - with set and reset high the data cell stores data on a clock edge.
// - with set and reset high and no clock edge the data cell holds.
`timescale 1ns/10ps
module ffmo_cells
  import ffmo_pkg::*;
#(
  parameter int unsigned TICK_CYC = FFMO_TICK_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic tr_toggle,
  input wire logic tr_reset_n,
  output logic tr_true_out,
  output logic tr_inverse_out,
  input wire logic ts_toggle,
  input wire logic ts_set_n,
  output logic ts_true_out,
  output logic ts_inverse_out,
  input wire logic mr_trig,
  input wire logic mr_retrig_en,
  input wire logic [FFMO_DLY_W-1:0] mr_dly_ticks,
  output logic mr_true_out,
  output logic mr_inverse_out,
  input wire logic mf_trig,
  input wire logic mf_retrig_en,
  input wire logic [FFMO_DLY_W-1:0] mf_dly_ticks,
  output logic mf_true_out,
  output logic mf_inverse_out,
  input wire logic df_clk_in,
  input wire logic df_data,
  input wire logic df_set_n,
  input wire logic df_reset_n,
  output logic df_true_out,
  output logic df_inverse_out
);
  // ****************************************
  // toggle cells
  // ****************************************
  // controls act at the next ref_clk edge, not truly asynchronously
  logic tr_t_d_ff;
  logic tr_q_ff;
  logic ts_t_d_ff;
  logic ts_q_ff;
  logic tr_rise;
  logic ts_rise;

  assign tr_rise = tr_toggle & ~tr_t_d_ff;
  assign ts_rise = ts_toggle & ~ts_t_d_ff;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tr_t_d_ff <= FFMO_LVL_LO;
      tr_q_ff <= FFMO_LVL_LO;
    end else begin
      tr_t_d_ff <= tr_toggle;
      if (!tr_reset_n) begin
        tr_q_ff <= FFMO_LVL_LO;
      end else if (tr_rise) begin
        tr_q_ff <= ~tr_q_ff;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ts_t_d_ff <= FFMO_LVL_LO;
      ts_q_ff <= FFMO_LVL_LO;
    end else begin
      ts_t_d_ff <= ts_toggle;
      if (!ts_set_n) begin
        ts_q_ff <= FFMO_LVL_HI;
      end else if (ts_rise) begin
        ts_q_ff <= ~ts_q_ff;
      end
    end
  end

  // hold is implied: no branch writes the state otherwise
  assign tr_true_out = tr_q_ff;
  assign tr_inverse_out = ~tr_q_ff;
  assign ts_true_out = ts_q_ff;
  assign ts_inverse_out = ~ts_q_ff;

  a_trst_force: assert property (
    @(posedge ref_clk) disable iff (rst)
    !tr_reset_n |=> !tr_true_out && tr_inverse_out)
    else $error("reset-toggle cell not forced low");
  a_tset_force: assert property (
    @(posedge ref_clk) disable iff (rst)
    !ts_set_n |=> ts_true_out && !ts_inverse_out)
    else $error("set-toggle cell not forced high");
  a_toggle_swap: assert property (
    @(posedge ref_clk) disable iff (rst)
    tr_reset_n && tr_rise |=> tr_true_out != $past(tr_true_out))
    else $error("toggle cell did not swap");
  a_tset_swap: assert property (
    @(posedge ref_clk) disable iff (rst)
    ts_set_n && ts_rise |=> ts_true_out != $past(ts_true_out))
    else $error("set-toggle cell did not swap");
  a_toggle_hold: assert property (
    @(posedge ref_clk) disable iff (rst)
    ts_set_n && !ts_rise |=> $stable(ts_true_out))
    else $error("toggle cell changed without edge");
  a_trst_hold: assert property (
    @(posedge ref_clk) disable iff (rst)
    tr_reset_n && !tr_rise |=> $stable(tr_true_out))
    else $error("reset-toggle cell changed without edge");

  // ****************************************
  // one-shots
  // ****************************************
  ffmo_oneshot #(
    .FALL_EDGE(1'b0),
    .TICK_CYC(TICK_CYC)
  ) u_shot_rise (
    .ref_clk(ref_clk),
    .rst(rst),
    .trig_in(mr_trig),
    .retrig_en(mr_retrig_en),
    .dly_ticks(mr_dly_ticks),
    .true_out(mr_true_out),
    .inverse_out(mr_inverse_out)
  );

  ffmo_oneshot #(
    .FALL_EDGE(1'b1),
    .TICK_CYC(TICK_CYC)
  ) u_shot_fall (
    .ref_clk(ref_clk),
    .rst(rst),
    .trig_in(mf_trig),
    .retrig_en(mf_retrig_en),
    .dly_ticks(mf_dly_ticks),
    .true_out(mf_true_out),
    .inverse_out(mf_inverse_out)
  );

  // ****************************************
  // data flip-flop with set and reset
  // ****************************************
  logic df_c_d_ff;
  logic df_q_ff;
  logic df_both_ff;
  logic df_rise;
  logic nxt_df_q;

  assign df_rise = df_clk_in & ~df_c_d_ff;
  // both controls low is a forced state that stores nothing
  assign nxt_df_q = !df_set_n ? FFMO_LVL_HI :
                    !df_reset_n ? FFMO_LVL_LO :
                    df_rise ? df_data : df_q_ff;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      df_c_d_ff <= FFMO_LVL_LO;
      df_q_ff <= FFMO_LVL_LO;
      df_both_ff <= FFMO_LVL_LO;
    end else begin
      df_c_d_ff <= df_clk_in;
      df_q_ff <= nxt_df_q;
      df_both_ff <= ~df_set_n & ~df_reset_n;
    end
  end

  assign df_true_out = df_q_ff;
  assign df_inverse_out = ~df_q_ff | df_both_ff;

  a_dff_set: assert property (
    @(posedge ref_clk) disable iff (rst)
    !df_set_n && df_reset_n |=> df_true_out && !df_inverse_out)
    else $error("data cell set failed");
  a_dff_reset: assert property (
    @(posedge ref_clk) disable iff (rst)
    df_set_n && !df_reset_n |=> !df_true_out && df_inverse_out)
    else $error("data cell reset failed");
  a_dff_both: assert property (
    @(posedge ref_clk) disable iff (rst)
    !df_set_n && !df_reset_n |=> df_true_out && df_inverse_out)
    else $error("data cell both-low state wrong");
  a_dff_store: assert property (
    @(posedge ref_clk) disable iff (rst)
    df_set_n && df_reset_n && df_rise |=>
      df_true_out == $past(df_data) && df_inverse_out != df_true_out)
    else $error("data cell did not store");
  a_dff_hold: assert property (
    @(posedge ref_clk) disable iff (rst)
    df_set_n && df_reset_n && !df_rise |=> $stable(df_true_out))
    else $error("data cell changed without clock edge");
endmodule

/* verif/ffmo_src.sv */
// far-side logic model that drives a one-shot trigger line
`timescale 1ns/10ps
module ffmo_src (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic idle_lvl,
  input wire logic fire,
  output logic trig
);
  // ****************************************
  // trigger pulse
  // ****************************************
  // one cycle away from idle per fire; callers leave a gap so the line
  // always rests at idle for at least one cycle between pulses
  logic pulse_ff;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pulse_ff <= 1'h0;
    end else begin
      pulse_ff <= fire;
    end
  end
  assign trig = idle_lvl ^ pulse_ff;
endmodule

/* verif/ffmo_cells_tb.sv */
// self-checking bench for the flip-flop and one-shot cell library
`timescale 1ns/10ps
module ffmo_cells_tb
  import ffmo_pkg::*;
;
  // short tick keeps pulses to a handful of cycles
  localparam int unsigned TCYC = 2;
  // {set_n, reset_n, data, clock pulse, true, inverse}
  localparam logic [5:0] DF_ROWS [7] = '{6'h3e, 6'h32, 6'h35, 6'h16,
    6'h2d, 6'h03, 6'h32};
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic [1:0] tg = 2'h0;
  logic [1:0] ctl_n = 2'h3;
  logic [1:0] fire = 2'h0;
  logic [1:0] rt_en = 2'h0;
  logic [FFMO_DLY_W-1:0] dly [2] = '{24'h2, 24'h2};
  logic df_clk_in = 1'h0;
  logic df_data = 1'h0;
  logic df_set_n = 1'h1;
  logic df_reset_n = 1'h1;
  logic mr_trig, mf_trig;
  logic tr_q, tr_qn, ts_q, ts_qn, mr_q, mr_qn, mf_q, mf_qn, df_q, df_qn;
  int miscompares = 0;
  int checked = 0;
  always #2.5 ref_clk = ~ref_clk;
  ffmo_src u_src_r (.ref_clk(ref_clk), .rst(rst), .idle_lvl(1'h0),
    .fire(fire[0]), .trig(mr_trig));
  ffmo_src u_src_f (.ref_clk(ref_clk), .rst(rst), .idle_lvl(1'h1),
    .fire(fire[1]), .trig(mf_trig));
  ffmo_cells #(.TICK_CYC(TCYC)) dut (.ref_clk(ref_clk), .rst(rst),
    .tr_toggle(tg[0]), .tr_reset_n(ctl_n[0]), .tr_true_out(tr_q),
    .tr_inverse_out(tr_qn), .ts_toggle(tg[1]), .ts_set_n(ctl_n[1]),
    .ts_true_out(ts_q), .ts_inverse_out(ts_qn), .mr_trig(mr_trig),
    .mr_retrig_en(rt_en[0]), .mr_dly_ticks(dly[0]), .mr_true_out(mr_q),
    .mr_inverse_out(mr_qn), .mf_trig(mf_trig), .mf_retrig_en(rt_en[1]),
    .mf_dly_ticks(dly[1]), .mf_true_out(mf_q), .mf_inverse_out(mf_qn),
    .df_clk_in(df_clk_in), .df_data(df_data), .df_set_n(df_set_n),
    .df_reset_n(df_reset_n), .df_true_out(df_q), .df_inverse_out(df_qn));
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %b want %b", $time, got, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic tog(input int w);
    @(posedge ref_clk) tg[w] <= 1'h1;
    @(posedge ref_clk) tg[w] <= 1'h0;
    step(3);
  endtask
  // counts high cycles over a fixed window, so no open-ended wait is needed
  task automatic shot(input int w, input logic rt, input logic [23:0] d,
    input logic twice, input int exp_len);
    int n;
    logic q;
    n = 0;
    @(posedge ref_clk);
    rt_en[w] <= rt;
    dly[w] <= d;
    for (int c = 0; c < 40; c++) begin
      @(posedge ref_clk);
      fire[w] <= (c == 1) || (twice && c == 3);
      #1;
      q = (w == 1) ? mf_q : mr_q;
      n += (q === 1'h1);
      chk({q, (w == 1) ? mf_qn : mr_qn}, {q, ~q});
    end
    chk(q, 1'h0);
    chk(n[1:0], exp_len[1:0]);
    chk(n[7:2], exp_len[7:2]);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'h0;
    step(2);
    chk({tr_q, tr_qn, ts_q, ts_qn}, 4'h5);
    chk({mr_q, mr_qn, mf_q, mf_qn, df_q, df_qn}, 6'h15);
    foreach (DF_ROWS[i]) begin
      @(posedge ref_clk);
      {df_set_n, df_reset_n, df_data, df_clk_in} <= DF_ROWS[i][5:2];
      @(posedge ref_clk) df_clk_in <= 1'h0;
      step(3);
      chk({df_q, df_qn},
        DF_ROWS[i][1:0]);
    end
    tog(0);
    chk({tr_q, tr_qn}, 2'h2);
    tog(0);
    chk({tr_q, tr_qn}, 2'h1);
    tog(0);
    step(5);
    chk({tr_q, tr_qn}, 2'h2);
    @(posedge ref_clk) ctl_n <= 2'h0;
    tog(0);
    tog(1);
    chk({tr_q, tr_qn, ts_q, ts_qn}, 4'h6);
    @(posedge ref_clk) ctl_n <= 2'h3;
    step(3);
    chk({tr_q, tr_qn, ts_q, ts_qn}, 4'h6);
    tog(1);
    chk({ts_q, ts_qn}, 2'h1);
    shot(0, 1'h0, 24'h2, 1'h0, 4);
    shot(0, 1'h0, 24'h2, 1'h1, 4);
    shot(0, 1'h1, 24'h2, 1'h1, 6);
    shot(1, 1'h0, 24'h1, 1'h0, 2);
    shot(1, 1'h1, 24'h2, 1'h1, 6);
    // a zero length is served as the one-tick minimum
    shot(1, 1'h0, 24'h0, 1'h0, 2);
    // mid-run reset: data cell holds 1 here and must drop to 0
    @(posedge ref_clk) rst <= 1'h1;
    step(2);
    chk({tr_q, tr_qn, ts_q, ts_qn, df_q, df_qn}, 6'h15);
    @(posedge ref_clk) rst <= 1'h0;
    step(2);
    tog(1);
    chk({ts_q, ts_qn}, 2'h2);
    tally_and_finish();
  end
endmodule
